// ---- timer_status_compare_regs.sv ----
// one 16-bit timer channel: up-counter, two comparators, event flags,
// interrupt mask, counter snapshot, capture register, wishbone slave
// assumes a single 40 MHz clock; capture pin is asynchronous to it
`include "timer_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_status_compare_regs #(
  parameter int ADDR_W = 8 // byte address width of the slave
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic capture_pin_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);

  // refuse address widths too narrow for the seven registers
  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W must be at least 6");
  end

  // merge a write into a 16-bit field under the two low byte enables
  function automatic logic [`COUNT_W-1:0] merge16(
    input logic [`COUNT_W-1:0] old_v,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    logic [`COUNT_W-1:0] res;
    res = old_v;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction : merge16

  // place a 16-bit value in the low half of a bus word
  function automatic logic [31:0] widen16(input logic [`COUNT_W-1:0] v);
    return {16'h0000, v};
  endfunction : widen16

  timer_regs_pkg::state_s q; // registered state
  timer_regs_pkg::state_s d; // next state

  // decode helpers
  logic take; // access taken at this edge
  logic mapped; // address hits the register window
  logic [2:0] idx; // word index
  logic running; // counter run enable
  logic hit_first; // comparator outputs
  logic hit_second;
  logic wrap; // counter at its top while running
  logic cap_rise; // synchronised capture edge
  timer_regs_pkg::event_s ev_set; // events of this cycle
  timer_regs_pkg::event_s ev_clr; // software clears of this cycle

  // request decode and event detection
  always_comb begin
    take = wb_cyc_i && wb_stb_i && !q.ack;
    mapped = (wb_adr_i[ADDR_W-1:5] == '0) && (wb_adr_i[4:2] <= `IDX_COUNTER_CONTROL);
    idx = wb_adr_i[4:2];
    running = q.ctrl[`BIT_CTRL_RUN];
    // comparators only fire while counting, once per counter value
    hit_first = running && (q.counter == q.cmp_first);
    hit_second = running && (q.counter == q.cmp_second);
    wrap = running && (q.counter == `COUNT_MAX);
    cap_rise = q.cap_sync[1] && !q.cap_prev;
    ev_set.match_first = hit_first;
    ev_set.match_second = hit_second;
    // a clear on second match at the top value prevents the wrap
    ev_set.overflow = wrap && !(hit_second && q.ctrl[`BIT_CTRL_CLEAR_ON_SECOND]);
    ev_clr = `EVENT_NONE;
    if (take && mapped && (idx == `IDX_EVENT_STATUS)) begin
      if (!wb_we_i) begin
        ev_clr = `EVENT_ALL;
      end else if (wb_sel_i[0]) begin
        ev_clr = wb_dat_i[`EVENT_W-1:0]; // write one to clear
      end
    end
  end

  // next-state logic of the whole block
  always_comb begin
    d = q;
    // capture pin: two flops, then edge detect on the second
    d.cap_sync = {q.cap_sync[0], capture_pin_i};
    d.cap_prev = q.cap_sync[1];
    if (cap_rise) begin
      d.captured = q.counter;
    end
    // 16-bit up-counter, cleared while stopped
    if (!running) begin
      d.counter = `COUNT_ZERO;
    end else if (hit_second && q.ctrl[`BIT_CTRL_CLEAR_ON_SECOND]) begin
      d.counter = `COUNT_ZERO;
    end else begin
      d.counter = q.counter + `COUNT_ONE;
    end
    // flags latch whatever the mask, and a new event beats a clear
    d.status = (q.status & ~ev_clr) | ev_set;
    // bus slave: one ack per request, dropped the cycle after
    d.ack = take;
    d.rdata = `WORD_ZERO;
    if (take && mapped) begin
      if (wb_we_i) begin
        // register writes; upper bits are never stored
        case (idx)
          `IDX_EVENT_MASK: begin
            if (wb_sel_i[0]) begin
              d.mask = wb_dat_i[`EVENT_W-1:0];
            end
          end
          `IDX_COMPARE_FIRST: begin
            d.cmp_first = merge16(q.cmp_first, wb_dat_i, wb_sel_i);
          end
          `IDX_COMPARE_SECOND: begin
            d.cmp_second = merge16(q.cmp_second, wb_dat_i, wb_sel_i);
          end
          `IDX_COUNTER_CONTROL: begin
            if (wb_sel_i[0]) begin
              d.ctrl = wb_dat_i[`CTRL_W-1:0];
            end
          end
          default: begin
            // status handled above, read-only registers ignore writes
          end
        endcase
      end else begin
        // register reads, sampled at the taking edge
        case (idx)
          `IDX_EVENT_STATUS: begin
            d.rdata = {29'h0000_0000, q.status};
          end
          `IDX_EVENT_MASK: begin
            d.rdata = {29'h0000_0000, q.mask};
          end
          `IDX_COUNTER_SNAPSHOT: begin
            d.rdata = widen16(q.counter);
          end
          `IDX_COMPARE_FIRST: begin
            d.rdata = widen16(q.cmp_first);
          end
          `IDX_COMPARE_SECOND: begin
            d.rdata = widen16(q.cmp_second);
          end
          `IDX_CAPTURED_FIRST: begin
            d.rdata = widen16(q.captured);
          end
          `IDX_COUNTER_CONTROL: begin
            d.rdata = {30'h0000_0000, q.ctrl};
          end
          default: begin
            d.rdata = `WORD_ZERO;
          end
        endcase
      end
    end
    // one level interrupt, gated per event by the mask
    d.irq = |(d.status & d.mask);
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q.status <= `EVENT_NONE;
      q.mask <= `EVENT_NONE;
      q.counter <= `COUNT_ZERO;
      q.cmp_first <= `COUNT_ZERO;
      q.cmp_second <= `COUNT_ZERO;
      q.captured <= `COUNT_ZERO;
      q.ctrl <= `CTRL_RESET;
      q.cap_sync <= `SYNC_RESET;
      q.cap_prev <= 1'b0;
      q.ack <= 1'b0;
      q.rdata <= `WORD_ZERO;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;

endmodule : timer_status_compare_regs

`default_nettype wire

// ---- timer_regs_map.svh ----
// register map, field positions and reset values of the timer event/compare block
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef TIMER_REGS_MAP_SVH
`define TIMER_REGS_MAP_SVH

// word index of each register (byte address is index times four)
`define IDX_EVENT_STATUS 3'h0
`define IDX_EVENT_MASK 3'h1
`define IDX_COUNTER_SNAPSHOT 3'h2
`define IDX_COMPARE_FIRST 3'h3
`define IDX_COMPARE_SECOND 3'h4
`define IDX_CAPTURED_FIRST 3'h5
`define IDX_COUNTER_CONTROL 3'h6

// event bit positions, shared by status and mask
`define BIT_MATCH_FIRST 0
`define BIT_MATCH_SECOND 1
`define BIT_OVERFLOW 2

// counter control bit positions
`define BIT_CTRL_RUN 0
`define BIT_CTRL_CLEAR_ON_SECOND 1

// widths, limits and reset values
`define EVENT_W 3
`define COUNT_W 16
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define EVENT_NONE 3'h0
`define EVENT_ALL 3'h7
`define CTRL_W 2
`define CTRL_RESET 2'h0
`define WORD_ZERO 32'h0000_0000
`define SYNC_RESET 2'h0

`endif

// ---- timer_regs_pkg.sv ----
// types of the timer event/compare register block
// assumes timer_regs_map.svh supplies the widths
`include "timer_regs_map.svh"

package timer_regs_pkg;

  // one bit per timer event, in status/mask bit order
  typedef struct packed {
    logic overflow;
    logic match_second;
    logic match_first;
  } event_s;

  // the whole state of the block
  typedef struct packed {
    event_s status;
    event_s mask;
    logic [`COUNT_W-1:0] counter;
    logic [`COUNT_W-1:0] cmp_first;
    logic [`COUNT_W-1:0] cmp_second;
    logic [`COUNT_W-1:0] captured;
    logic [`CTRL_W-1:0] ctrl;
    logic [1:0] cap_sync;
    logic cap_prev;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } state_s;

endpackage : timer_regs_pkg

// ---- timer_regs_monitor.sv ----
// port checker for the timer event and compare register slave
// assumes one clock domain and an active low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module timer_regs_monitor #(
  parameter int ADDR_W = 8 // byte address width
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic capture_pin_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper half not zero");
  chk_event_narrow: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[4:2] < 3'h2)
    |-> wb_dat_o[31:3] == 29'h0000_0000)
    else $error("status or mask wider than three bits");
  chk_masked_quiet: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == ADDR_W'(4))
    && wb_dat_o[2:0] == 3'h0 |-> !irq_o)
    else $error("interrupt with all events masked");
  chk_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[4:2] == 3'h7)
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($rose(rst_n_i) |-> !wb_ack_o && !irq_o)
    else $error("outputs active after reset");
endmodule : timer_regs_monitor
bind timer_status_compare_regs timer_regs_monitor #(.ADDR_W(ADDR_W)) mon (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .capture_pin_i(capture_pin_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// ---- test_timer_status_compare_regs.sv ----
// self-checking bench for the timer event and compare register slave
// assumes the design files and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_timer_status_compare_regs;
  logic clk_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b0;
  logic [7:0] adr = 8'h00; // byte address
  logic [3:0] sel = 4'hf; // byte enables, narrowed for partial writes
  logic [31:0] wdat = 32'h0000_0000, rdat, r1, r2, dat_o;
  logic ack_o, irq_o;
  logic [31:0] exp_q[$], msk_q[$]; // expected answers and compared bits
  int errors = 0, comparisons = 0, cycles = 0, t0, t1;
  timer_status_compare_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .capture_pin_i(pin),
    .wb_dat_o(dat_o), .wb_ack_o(ack_o), .irq_o(irq_o));
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // counts one comparison, reports a mismatch
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // verdict and end of run
  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // one classic cycle, noting the expected answer first
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    t0 = cycles;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // answer checker and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors++;
      wrap_up();
    end
    if (ack_o === 1'b1) begin
      rdat = dat_o;
      cmp(dat_o & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // main sequence
  initial begin
    void'($urandom(14));
    r1 = $urandom;
    r2 = $urandom;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) bus(1'b0, 8'(i * 4), 0, 0, '1);
    bus(1'b1, 8'h0c, r1, 0, 0);
    bus(1'b1, 8'h10, r2, 0, 0);
    bus(1'b1, 8'h04, r1 ^ r2, 0, 0);
    bus(1'b0, 8'h0c, 0, r1 & 32'h0000_ffff, '1);
    bus(1'b0, 8'h10, 0, r2 & 32'h0000_ffff, '1);
    bus(1'b0, 8'h04, 0, (r1 ^ r2) & 32'h0000_0007, '1);
    bus(1'b1, 8'h04, 0, 0, 0);
    bus(1'b0, 8'h04, 0, 0, '1);
    bus(1'b1, 8'h0c, 32'h0000_0014, 0, 0);
    sel <= 4'h2;
    bus(1'b1, 8'h0c, 32'h0000_00ff, 0, 0);
    sel <= 4'hf;
    bus(1'b0, 8'h0c, 0, 32'h0000_0014, '1);
    bus(1'b1, 8'h10, 32'h0000_0028, 0, 0);
    bus(1'b1, 8'h18, 32'h0000_0001, 0, 0);
    repeat (60) @(posedge clk_i);
    cmp({31'h0000_0000, irq_o}, 0);
    bus(1'b1, 8'h04, 32'h0000_0001, 0, 0);
    repeat (3) @(posedge clk_i);
    cmp({31'h0000_0000, irq_o}, 1);
    bus(1'b0, 8'h00, 0, 32'h0000_0003, '1);
    bus(1'b0, 8'h00, 0, 0, '1);
    cmp({31'h0000_0000, irq_o}, 0);
    bus(1'b0, 8'h08, 0, 0, 32'hffff_0000);
    r1 = rdat;
    t1 = t0;
    bus(1'b0, 8'h08, 0, 0, 32'hffff_0000);
    cmp((rdat - r1) & 32'h0000_ffff, 32'(t0 - t1));
    pin <= 1'b1;
    bus(1'b0, 8'h14, 0, 0, 32'hffff_0000);
    bus(1'b1, 8'h04, 32'h0000_0006, 0, 0);
    while (irq_o !== 1'b1) @(posedge clk_i);
    bus(1'b0, 8'h00, 0, 32'h0000_0004, '1);
    cmp({31'h0000_0000, irq_o}, 0);
    wrap_up();
  end
endmodule : test_timer_status_compare_regs
`default_nettype wire
